/* File: core/hsp_pkg.sv */
// Shared constants and types for the hot-swap protection control logic.
// Assumes a 25 MHz system clock and a command port fed by an upstream
// transaction decoder running on its own link clock.
package hsp_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_OPERATION = 8'h03;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h04;
  localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_TEMPERATURE = 8'h8D;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hD8;
  localparam logic [7:0] CMD_DEVICE_SETUP = 8'hD9;
  localparam logic [7:0] CMD_DIAG = 8'hE1;
  localparam logic [7:0] OP_ON = 8'h80;
  localparam logic [7:0] OP_OFF = 8'h00;

  // ****************************************
  // Reset values (temperatures in whole degrees)
  // ****************************************
  localparam logic [7:0] OPERATION_RST = 8'h80;
  localparam logic [15:0] OT_FAULT_RST = 16'h0096;
  localparam logic [15:0] OT_WARN_RST = 16'h007D;
  localparam logic [15:0] ALERT_MASK_RST = 16'h0000;
  localparam logic [2:0] RETRY_SEL_RST = 3'h0;
  localparam logic [2:0] RETRY_SEL_UNLIMITED = 3'h6;

  // ****************************************
  // Field positions (combined_diag_status and alert mask share the DG ones; VS_SHORT is vendor status)
  // ****************************************
  localparam int DG_OT_WARN = 0;
  localparam int DG_OT_FAULT = 1;
  localparam int DG_SHORT = 2;
  localparam int DG_LATCHED = 3;
  localparam int DG_UV = 4;
  localparam int DG_OV = 5;
  localparam int DG_GATE = 6;
  localparam int VS_SHORT = 7;
  localparam logic [15:0] ALERT_BITS = 16'h0037;

  // ****************************************
  // Address straps
  // ****************************************
  localparam logic [6:0] ADDR_BASE = 7'h40;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_HZ = 25000000;
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int DIODE_PULSE_US = 40;
  localparam int SAMPLE_CYCLES = SYS_CLK_HZ / 1000000 * SAMPLE_PERIOD_US;
  localparam int PULSE_CYCLES = SYS_CLK_HZ / 1000000 * DIODE_PULSE_US;

  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } hsp_req_type;

endpackage : hsp_pkg

/* File: core/hsp_control.sv */
// Hot-swap protection control: temperature limits, shorted switch
// detection, gate enable, alert line, strap address and command port.
// Assumes pin comparators arrive asynchronously, the temperature sample
// and retry event come from same-clock logic, and the link decoder
// drives the request port on pm_clk.
//
// Behaviour
// - Pulse diode current once every millisecond
// - Temperature above warn limit pulls alert
// - Temperature above fault limit turns gate off
// - Host may rewrite both temperature limits
// - Temperature command returns latest sample
// - Sense above 4 mV with gate low
// - Short sets status bits, alerts unless masked
// - Enable low or overvolt forces gate off
// - Enable toggle clears latched-off state
// - Pins other than reference hold never disturb address or configuration
// - Operation 80h enables, 0h disables gate
// - Latch three-level strap address after supply
// - Reference hold low postpones address capture
// - Reference hold low resets logic and values
// - Latch address once reference exceeds 2.4 V
// - Latched bit set while latched off
// - Retry limit 0,1,2,4,8,16 or unlimited
`timescale 1ns/1ps
`default_nettype none

module hsp_control #(
  parameter int SAMPLE_CYCLES = hsp_pkg::SAMPLE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pm_clk,
  input wire logic pm_reset,
  input wire logic pm_req_valid,
  input wire hsp_pkg::hsp_req_type pm_req,
  output logic pm_busy,
  output logic pm_ack,
  output logic [15:0] pm_rdata,
  input wire logic undervolt_enable_input,
  input wire logic overvolt_input,
  input wire logic ref_hold_low,
  input wire logic ref_above_2v4,
  input wire logic vdd_por_ok,
  input wire logic [1:0] addr_strap_0,
  input wire logic [1:0] addr_strap_1,
  input wire logic [1:0] addr_strap_2,
  input wire logic sense_over_4mv,
  input wire logic gate_low_sensed,
  input wire logic temp_valid,
  input wire logic [15:0] temp_value,
  input wire logic retry_exhausted,
  output logic gate_drive_on,
  output logic diode_pulse_on,
  output logic alert_line_o,
  output logic alert_line_oe,
  output logic [6:0] bus_address,
  output logic addr_valid,
  output logic [2:0] retry_limit_sel
);

  localparam int CW = $clog2(SAMPLE_CYCLES);
  localparam int NP = 13;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] pin_s1;
  logic [NP-1:0] pin_s2;
  logic uv_ok, ov_hi, ref_low, ref_ok, por_ok, sense_hi, gate_low;
  logic [1:0] strap0, strap1, strap2;

  assign pin_raw = {undervolt_enable_input, overvolt_input, ref_hold_low,
                    ref_above_2v4, vdd_por_ok, addr_strap_0, addr_strap_1,
                    addr_strap_2, sense_over_4mv, gate_low_sensed};

  // Two stages; only the second stage is read by logic
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  assign {uv_ok, ov_hi, ref_low, ref_ok, por_ok, strap0, strap1, strap2,
          sense_hi, gate_low} = pin_s2;

  // Reference hold low resets all volatile state except pin synchronisers and handshake
  logic logic_rst;
  assign logic_rst = reset | ref_low;

  // ****************************************
  // Link side of the command handshake
  // ****************************************
  hsp_pkg::hsp_req_type req_hold;
  logic req_tgl, ack_tgl;
  logic ack_l1, ack_l2, ack_l3;
  logic [15:0] rdata_hold;

  // One command in flight; requests while busy are ignored
  always_ff @(posedge pm_clk)
  begin
    if (pm_reset)
    begin
      req_hold <= '0;
      req_tgl <= 1'b0;
      pm_busy <= 1'b0;
      pm_ack <= 1'b0;
      pm_rdata <= '0;
      ack_l1 <= 1'b0;
      ack_l2 <= 1'b0;
      ack_l3 <= 1'b0;
    end
    else
    begin
      ack_l1 <= ack_tgl;
      ack_l2 <= ack_l1;
      ack_l3 <= ack_l2;
      pm_ack <= ack_l2 ^ ack_l3;
      if (ack_l2 ^ ack_l3)
      begin
        pm_rdata <= rdata_hold; // Held stable by the toggle handshake
        pm_busy <= 1'b0;
      end
      else if (pm_req_valid && !pm_busy)
      begin
        req_hold <= pm_req;
        req_tgl <= ~req_tgl;
        pm_busy <= 1'b1;
      end
    end
  end

  // ****************************************
  // System side of the command handshake
  // ****************************************
  logic req_s1, req_s2, req_s3, req_evt, wr_evt;

  // Chip reset only, so a reference hold cannot replay a stale command
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end
    else
    begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  assign req_evt = req_s2 ^ req_s3;
  assign wr_evt = req_evt & req_hold.write;

  // ****************************************
  // Host registers
  // ****************************************
  logic [7:0] op_ctl;
  logic [15:0] ot_fault_lim, ot_warn_lim, alert_mask, temp_reg;

  // Only reset or reference hold restore defaults, never the pins
  always_ff @(posedge clk_sys)
  begin
    if (logic_rst)
    begin
      op_ctl <= hsp_pkg::OPERATION_RST;
      ot_fault_lim <= hsp_pkg::OT_FAULT_RST;
      ot_warn_lim <= hsp_pkg::OT_WARN_RST;
      alert_mask <= hsp_pkg::ALERT_MASK_RST;
      retry_limit_sel <= hsp_pkg::RETRY_SEL_RST;
    end
    else if (wr_evt)
    begin
      unique case (req_hold.code)
        hsp_pkg::CMD_OPERATION: op_ctl <= req_hold.wdata[7:0];
        hsp_pkg::CMD_OT_FAULT: ot_fault_lim <= req_hold.wdata;
        hsp_pkg::CMD_OT_WARN: ot_warn_lim <= req_hold.wdata;
        hsp_pkg::CMD_ALERT_MASK: alert_mask <= req_hold.wdata;
        // Codes 6 and 7 both mean unlimited retries
        hsp_pkg::CMD_DEVICE_SETUP: retry_limit_sel <=
          (req_hold.wdata[2:0] > hsp_pkg::RETRY_SEL_UNLIMITED) ?
          hsp_pkg::RETRY_SEL_UNLIMITED : req_hold.wdata[2:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Temperature sampling and limits
  // ****************************************
  logic [CW-1:0] tick_cnt;

  // Free-running millisecond frame with a short current step at its start
  always_ff @(posedge clk_sys)
  begin
    if (logic_rst)
    begin
      tick_cnt <= '0;
      diode_pulse_on <= 1'b0;
    end
    else
    begin
      tick_cnt <= (tick_cnt == CW'(SAMPLE_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
      diode_pulse_on <= (tick_cnt < CW'(hsp_pkg::PULSE_CYCLES));
    end
  end

  logic flag_warn, flag_fault, flag_short, latched_off, armed;
  logic clr_evt, warn_hit, fault_hit, short_hit, uv_prev;
  assign clr_evt = wr_evt && (req_hold.code == hsp_pkg::CMD_CLEAR_FAULTS);
  assign warn_hit = temp_valid && (temp_value > ot_warn_lim);
  assign fault_hit = temp_valid && (temp_value > ot_fault_lim);
  // Trust the internal command as well as the sensed gate level
  assign short_hit = sense_hi && (gate_low || !gate_drive_on);

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (logic_rst)
    begin
      temp_reg <= '0;
      flag_warn <= 1'b0;
      flag_fault <= 1'b0;
      flag_short <= 1'b0;
    end
    else
    begin
      if (temp_valid)
        temp_reg <= temp_value;
      flag_warn <= warn_hit | (flag_warn & ~clr_evt);
      flag_fault <= fault_hit | (flag_fault & ~clr_evt);
      flag_short <= short_hit | (flag_short & ~clr_evt);
    end
  end

  // ****************************************
  // Gate control
  // ****************************************
  // Latched off until the enable pin changes; arming demands a 0h write
  always_ff @(posedge clk_sys)
  begin
    if (logic_rst)
    begin
      uv_prev <= 1'b0;
      latched_off <= 1'b0;
      armed <= 1'b1;
    end
    else
    begin
      uv_prev <= uv_ok;
      latched_off <= retry_exhausted | (latched_off & ~(uv_ok ^ uv_prev));
      if (fault_hit)
        armed <= 1'b0;
      else if (wr_evt && req_hold.code == hsp_pkg::CMD_OPERATION &&
               req_hold.wdata[7:0] == hsp_pkg::OP_OFF)
        armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (logic_rst)
      gate_drive_on <= 1'b0;
    else
      gate_drive_on <= (op_ctl == hsp_pkg::OP_ON) && armed &&
                       uv_ok && !ov_hi &&
                       !flag_fault && !latched_off;
  end

  // ****************************************
  // Status words and alert line
  // ****************************************
  logic [15:0] diag;
  logic [7:0] vstatus;
  always_comb
  begin
    diag = '0;
    diag[hsp_pkg::DG_OT_WARN] = flag_warn;
    diag[hsp_pkg::DG_OT_FAULT] = flag_fault;
    diag[hsp_pkg::DG_SHORT] = flag_short;
    diag[hsp_pkg::DG_LATCHED] = latched_off;
    diag[hsp_pkg::DG_UV] = ~uv_ok;
    diag[hsp_pkg::DG_OV] = ov_hi;
    diag[hsp_pkg::DG_GATE] = gate_drive_on;
    vstatus = '0;
    vstatus[hsp_pkg::VS_SHORT] = flag_short;
  end

  // Open-drain: the line is only ever pulled low
  always_ff @(posedge clk_sys)
  begin
    if (logic_rst)
    begin
      alert_line_o <= 1'b0;
      alert_line_oe <= 1'b0;
    end
    else
    begin
      alert_line_o <= 1'b0;
      alert_line_oe <= |(diag & hsp_pkg::ALERT_BITS & ~alert_mask);
    end
  end

  // Read answer; writes and unmapped codes answer zero
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdata_hold <= '0;
      ack_tgl <= 1'b0;
    end
    else if (req_evt)
    begin
      ack_tgl <= ~ack_tgl;
      rdata_hold <= '0;
      if (!req_hold.write)
      begin
        unique case (req_hold.code)
          hsp_pkg::CMD_OPERATION: rdata_hold <= {8'h00, op_ctl};
          hsp_pkg::CMD_OT_FAULT: rdata_hold <= ot_fault_lim;
          hsp_pkg::CMD_OT_WARN: rdata_hold <= ot_warn_lim;
          hsp_pkg::CMD_VENDOR_STATUS: rdata_hold <= {8'h00, vstatus};
          hsp_pkg::CMD_TEMPERATURE: rdata_hold <= temp_reg;
          hsp_pkg::CMD_ALERT_MASK: rdata_hold <= alert_mask;
          hsp_pkg::CMD_DEVICE_SETUP: rdata_hold <= {13'h0000, retry_limit_sel};
          hsp_pkg::CMD_DIAG: rdata_hold <= diag;
          default: rdata_hold <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // Strap address capture
  // ****************************************
  function automatic logic [6:0] strap_val(input logic [1:0] s);
    strap_val = (s == hsp_pkg::STRAP_HIGH) ? 7'h02 :
                (s == hsp_pkg::STRAP_OPEN) ? 7'h01 : 7'h00;
  endfunction : strap_val

  // Waits for supply and reference; a hold restarts the capture
  always_ff @(posedge clk_sys)
  begin
    if (logic_rst)
    begin
      addr_valid <= 1'b0;
      bus_address <= '0;
    end
    else if (!addr_valid && por_ok && ref_ok)
    begin
      addr_valid <= 1'b1;
      bus_address <= hsp_pkg::ADDR_BASE + 7'(strap_val(strap2) * 7'h09) +
                     7'(strap_val(strap1) * 7'h03) + strap_val(strap0);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (logic_rst);

  chk_diode_frame: assert property ($rose(diode_pulse_on) |=>
    diode_pulse_on [*8])
    else $error("diode pulse too short");
  chk_warn_alert: assert property (warn_hit &&
    !alert_mask[hsp_pkg::DG_OT_WARN] |=> ##1 alert_line_oe)
    else $error("warn limit did not pull alert");
  chk_fault_gate: assert property (fault_hit |=> ##1 !gate_drive_on)
    else $error("fault limit left gate on");
  chk_limit_write: assert property (wr_evt &&
    req_hold.code == hsp_pkg::CMD_OT_WARN |=>
    ot_warn_lim == $past(req_hold.wdata))
    else $error("warn limit not updated");
  chk_temp_read: assert property (req_evt && !req_hold.write &&
    req_hold.code == hsp_pkg::CMD_TEMPERATURE |=>
    rdata_hold == $past(temp_reg))
    else $error("temperature read wrong");
  chk_short_flag: assert property (sense_hi && !gate_drive_on |=>
    flag_short && vstatus[hsp_pkg::VS_SHORT])
    else $error("short not flagged");
  chk_pin_off: assert property ((!uv_ok || ov_hi) |=> !gate_drive_on)
    else $error("pin did not force gate off");
  chk_latch_hold: assert property (retry_exhausted |=>
    diag[hsp_pkg::DG_LATCHED] ##1 !gate_drive_on)
    else $error("latched state not shown");
  chk_op_off: assert property (wr_evt &&
    req_hold.code == hsp_pkg::CMD_OPERATION &&
    req_hold.wdata[7:0] == hsp_pkg::OP_OFF |=> ##1 !gate_drive_on)
    else $error("operation off ignored");
  chk_addr_stable: assert property (addr_valid |=>
    $stable(bus_address) && addr_valid)
    else $error("address changed while powered");

  cov_short: cover property (flag_short && alert_line_oe);
  cov_fault_rearm: cover property (!armed ##[1:1000] armed);
  cov_latch_clear: cover property ($fell(latched_off));

endmodule : hsp_control

`default_nettype wire

/* File: test/hsp_host_model.sv */
// Host model on the command port, clocked by the link clock.
// Assumes the bench calls xfer one command at a time.
`timescale 1ns/1ps
`default_nettype none

module hsp_host_model (
  input wire logic pm_clk,
  input wire logic pm_busy,
  input wire logic pm_ack,
  input wire logic [15:0] pm_rdata,
  output logic pm_req_valid,
  output var hsp_pkg::hsp_req_type pm_req
);
  // Commands that never saw an answer; the bench counts them as mismatches
  int timeouts = 0;

  // ****************************************
  // Command issue
  // ****************************************
  initial
  begin
    pm_req_valid = 1'b0;
    pm_req = '0;
  end

  // Hold the request until taken; park the bus inverted so no stale
  // value is left looking valid
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [15:0] wd, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge pm_clk);
    pm_req_valid <= 1'b1;
    pm_req <= {wr, code, wd};
    @(posedge pm_clk);
    while (pm_busy !== 1'b0 && n < 50)
    begin
      @(posedge pm_clk);
      n++;
    end
    pm_req_valid <= 1'b0;
    pm_req <= ~pm_req;
    while (pm_ack !== 1'b1 && n < 100)
    begin
      @(posedge pm_clk);
      n++;
    end
    if (pm_ack !== 1'b1)
      timeouts++;
    rd = pm_rdata;
  endtask : xfer
endmodule : hsp_host_model

`default_nettype wire

/* File: test/hsp_control_tb.sv */
// Self-checking bench for the hot-swap protection control block.
// Assumes hsp_host_model drives the command port on the link clock.
`timescale 1ns/1ps
`default_nettype none

module hsp_control_tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int SAMP = 2000;
  typedef struct packed {logic [15:0] t; logic oe; logic g;} hsp_row_type;
  logic clk_sys, reset, pm_clk, pm_reset, pm_req_valid, pm_busy, pm_ack;
  hsp_pkg::hsp_req_type pm_req;
  logic [15:0] pm_rdata, temp_value, v;
  logic uv, ov, hold, ref_ok, vdd, sense, glow, temp_valid, retry_ex;
  logic [1:0] s0, s1, s2;
  logic gate, diode, al_o, al_oe, addr_valid;
  logic [6:0] addr;
  logic [2:0] rsel;
  int fail_count, compares, cycles, n;
  hsp_row_type rows [5] = '{'{16'h0019, 1'b0, 1'b1},
    '{16'h007D, 1'b0, 1'b1}, '{16'h007E, 1'b1, 1'b1},
    '{16'h0096, 1'b1, 1'b1}, '{16'h0097, 1'b1, 1'b0}};
  logic [7:0] rc [5] = '{8'h03, 8'h4F, 8'h51, 8'hD8, 8'h10};
  logic [15:0] rv [5] = '{16'h0080, 16'h0096, 16'h007D, 16'h0000, 16'h0000};

  hsp_control #(.SAMPLE_CYCLES(SAMP)) DUT (.clk_sys(clk_sys),
    .reset(reset), .pm_clk(pm_clk), .pm_reset(pm_reset),
    .pm_req_valid(pm_req_valid), .pm_req(pm_req), .pm_busy(pm_busy),
    .pm_ack(pm_ack), .pm_rdata(pm_rdata), .undervolt_enable_input(uv),
    .overvolt_input(ov), .ref_hold_low(hold), .ref_above_2v4(ref_ok),
    .vdd_por_ok(vdd), .addr_strap_0(s0), .addr_strap_1(s1),
    .addr_strap_2(s2), .sense_over_4mv(sense), .gate_low_sensed(glow),
    .temp_valid(temp_valid), .temp_value(temp_value),
    .retry_exhausted(retry_ex), .gate_drive_on(gate),
    .diode_pulse_on(diode), .alert_line_o(al_o), .alert_line_oe(al_oe),
    .bus_address(addr), .addr_valid(addr_valid), .retry_limit_sel(rsel));
  hsp_host_model HOST (.pm_clk(pm_clk), .pm_busy(pm_busy),
    .pm_ack(pm_ack), .pm_rdata(pm_rdata), .pm_req_valid(pm_req_valid),
    .pm_req(pm_req));

  // Link clock kept out of phase with the system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    pm_clk = 1'b0;
    #1.7;
    forever #3 pm_clk = ~pm_clk;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report;
    fail_count += HOST.timeouts; // A lost answer is a mismatch
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    HOST.xfer(1'b1, c, d, v);
    cyc(2);
  endtask : wr
  task automatic rd(input logic [7:0] c);
    HOST.xfer(1'b0, c, 16'h0000, v);
  endtask : rd
  // One completed sample; outputs settle two edges later
  task automatic samp(input logic [15:0] t);
    @(negedge clk_sys);
    temp_value = t;
    temp_valid = 1'b1;
    @(negedge clk_sys);
    temp_valid = 1'b0;
    cyc(3);
  endtask : samp
  // Host recovery order after a fault: clear, off, on
  task automatic rearm;
    wr(8'h04, 16'h0000);
    wr(8'h03, 16'h0000);
    wr(8'h03, 16'h0080);
    cyc(4);
  endtask : rearm

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {fail_count, compares, cycles} = '0;
    {reset, pm_reset, uv, ref_ok, vdd} = 5'h1F;
    {ov, hold, sense, glow, temp_valid, retry_ex} = 6'h00;
    {s0, s1, s2, temp_value} = {2'h1, 2'h2, 2'h0, 16'h0000};
    cyc(20);
    reset = 1'b0;
    @(negedge pm_clk) pm_reset = 1'b0;
    cyc(4);
    chk(16'(addr), 16'h0047);
    wr(8'h10, 16'hFFFF);
    for (int i = 0; i < 5; i++)
    begin
      rd(rc[i]);
      chk(v, rv[i]);
    end
    $display("test reset_values done");
    foreach (rows[i])
    begin
      rearm();
      chk(16'(gate), 16'h0001);
      samp(rows[i].t);
      chk(16'(al_oe), 16'(rows[i].oe));
      chk(16'(gate), 16'(rows[i].g));
      rd(8'h8D);
      chk(v, rows[i].t);
      chk(16'(pm_busy), 16'h0000);
    end
    chk(16'(al_o), 16'h0000);
    $display("test temp_table done");
    rearm();
    wr(8'h51, 16'h003C);
    wr(8'h4F, 16'h0046);
    samp(16'h0041);
    chk({14'h0, al_oe, gate}, 16'h0003);
    samp(16'h0047);
    chk(16'(gate), 16'h0000);
    rd(8'h51);
    chk(v, 16'h003C);
    $display("test limits done");
    rearm();
    sense = 1'b1;
    cyc(4);
    chk(16'(al_oe), 16'h0000);
    wr(8'h03, 16'h0000);
    chk(16'(gate), 16'h0000);
    // Gate off, then flag, then alert: two more edges after the gate
    cyc(3);
    chk(16'(al_oe), 16'h0001);
    rd(8'h80);
    chk(v, 16'h0080);
    sense = 1'b0;
    wr(8'hD8, 16'h0004);
    rearm();
    {sense, glow} = 2'h3;
    cyc(4);
    chk(16'(al_oe), 16'h0000);
    rd(8'hE1);
    chk(16'(v[2]), 16'h0001);
    {sense, glow} = 2'h0;
    wr(8'hD8, 16'h0000);
    rearm();
    $display("test short done");
    for (int i = 0; i < 7; i++)
    begin
      wr(8'hD9, 16'(i));
      chk(16'(rsel), 16'(i));
    end
    // Code 7 also means unlimited
    wr(8'hD9, 16'h0007);
    chk(16'(rsel), 16'h0006);
    uv = 1'b0;
    cyc(4);
    chk(16'(gate), 16'h0000);
    {uv, ov} = 2'h3;
    cyc(4);
    chk(16'(gate), 16'h0000);
    ov = 1'b0;
    cyc(4);
    chk(16'(gate), 16'h0001);
    retry_ex = 1'b1;
    cyc(1);
    retry_ex = 1'b0;
    cyc(12);
    rd(8'hE1);
    chk({v[3], 14'h0, gate}, 16'h8000);
    uv = 1'b0;
    cyc(4);
    uv = 1'b1;
    cyc(4);
    rd(8'hE1);
    chk({v[3], 14'h0, gate}, 16'h0001);
    rd(8'h51);
    chk(v, 16'h003C);
    chk(16'(addr), 16'h0047);
    $display("test pins done");
    n = 0;
    while (diode !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    repeat (SAMP)
    begin
      @(negedge clk_sys);
      if (diode === 1'b1)
        n++;
    end
    chk(16'(n), 16'(hsp_pkg::PULSE_CYCLES));
    {hold, ref_ok, s2} = 4'h9;
    cyc(4);
    chk(16'(addr_valid), 16'h0000);
    hold = 1'b0;
    cyc(4);
    chk(16'(addr_valid), 16'h0000);
    rd(8'h51);
    chk(v, 16'h007D);
    ref_ok = 1'b1;
    cyc(4);
    chk({addr_valid, 8'h0, addr}, 16'h8050);
    $display("test diode_address done");
    final_report();
  end
endmodule : hsp_control_tb

`default_nettype wire
